// >>> include/rsac_params.svh
/*
 * Constants for the resolver setup and alignment command path: command codes,
 * status bit positions and reset values.
 * Assumes it is included by bare name from files that use the rsac_ prefix.
 */
`ifndef RSAC_PARAMS_SVH
`define RSAC_PARAMS_SVH

// Block geometry
`define RSAC_NWORDS 10
`define RSAC_XMIT_BIT 15

// Command words
`define RSAC_CMD_SAVE_EXIT 16'h800E
`define RSAC_CMD_EXIT 16'h800F
`define RSAC_CMD_ALIGN_ENTER 16'h9000
`define RSAC_ALIGN_PASSWORD 16'h1298
`define RSAC_CMD_ALIGN_XDCR 16'h9001
`define RSAC_CMD_SETUP_ENTER 16'hA000
`define RSAC_CMD_FAULT_CLR 16'hA100
`define RSAC_CMD_PROG_CH1 16'hB011
`define RSAC_CMD_PROG_CH2 16'hB021
`define RSAC_CMD_PROG_BOTH 16'hB031
`define RSAC_CMD_PROG_NATIVE 16'hB002
`define RSAC_CMD_PROG_FOREIGN 16'hB004

// Setup word fields
`define RSAC_SW_DIR 0
`define RSAC_SW_LATCH 1
`define RSAC_SW_GEAR 8
`define RSAC_SW_RESET 16'h0000

// Module status word fields
`define RSAC_MS_ACK 15
`define RSAC_MS_ALIGN 13
`define RSAC_MS_INIT 12
`define RSAC_ERR_NONE 4'h0
`define RSAC_ERR_CMD 4'h1

// Channel status word fields
`define RSAC_CS_FAULT 15
`define RSAC_CS_ALIGNED 14

// Alignment resolution: 1024 counts per turn
`define RSAC_ALIGN_BITS 10

// Host register map (APB byte addresses)
`define RSAC_OUT_BASE 8'h00
`define RSAC_IN_BASE 8'h40

`endif

// >>> include/rsac_pkg.sv
/*
 * Types shared by both ends of the resolver command link.
 * Assumes rsac_params.svh is available on the include path.
 */
`default_nettype none
package rsac_pkg;
    // One 16-bit network word
    typedef logic [15:0] rsac_word_t;
    // Operating modes, Gray along setup -> measurement -> alignment
    typedef enum logic [1:0] {
        RSAC_MODE_SETUP = 2'h0,
        RSAC_MODE_MEAS = 2'h1,
        RSAC_MODE_ALIGN = 2'h3
    } rsac_mode_e;
    // Transducer configuration held with the setup data
    typedef enum logic [1:0] {
        RSAC_CFG_SINGLE = 2'h0,
        RSAC_CFG_NATIVE = 2'h1,
        RSAC_CFG_FOREIGN = 2'h2
    } rsac_cfg_e;
endpackage
`default_nettype wire

// >>> include/rsac_link_if.sv
/*
 * Network link between host controller and resolver module: ten output words
 * from the host, ten input words from the module.
 * Assumes both ends run on the same clock; the bench joins them.
 */
`default_nettype none
interface rsac_link_if;
    rsac_pkg::rsac_word_t out_w [10]; // Host to module, word 0 is the command
    rsac_pkg::rsac_word_t in_w [10];  // Module to host, word 0 is module status
    modport host (output out_w, input in_w);
    modport dev (input out_w, output in_w);
endinterface
`default_nettype wire

// >>> hdl/rsac_host.sv
/*
 * Host end: APB slave holding ten output words that drive the link and ten
 * read-only input words sampled from it.
 * Assumes one clock shared with the module end and an APB master on the bus.
 */
`include "rsac_params.svh"
`default_nettype none
module rsac_host (
    input wire logic clock,
    input wire logic rst_n,
    rsac_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // Map a byte address to a word slot; bit 4 set flags the input bank
    function automatic logic [5:0] slot(input logic [7:0] a);
        logic [7:0] off;
        off = 8'h00;
        if (a[1:0] != 2'h0) begin
            return 6'h3F;
        end
        if (a >= `RSAC_IN_BASE) begin
            off = a - `RSAC_IN_BASE;
            return (off < 8'h28) ? {2'h1, off[5:2]} : 6'h3F;
        end
        off = a - `RSAC_OUT_BASE;
        return (off < 8'h28) ? {2'h0, off[5:2]} : 6'h3F;
    endfunction

    logic [5:0] s;       // Decoded slot of the current request
    logic fire;          // Access phase completing this edge
    rsac_pkg::rsac_word_t outw [10]; // Output words driven onto the link

    assign s = slot(paddr);
    assign fire = psel & penable & pready;

    // Drive the link straight from the registers
    always_comb begin
        for (int i = 0; i < `RSAC_NWORDS; i++) begin
            link.out_w[i] = outw[i];
        end
    end

    // One wait-free access: ready rises in the first access cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // Read data and error answer captured in the setup cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr <= (s == 6'h3F) | (pwrite & s[4]);
            if (s == 6'h3F) begin
                prdata <= 32'h0000_0000;
            end else if (s[4]) begin
                prdata <= {16'h0000, link.in_w[s[3:0]]};
            end else begin
                prdata <= {16'h0000, outw[s[3:0]]};
            end
        end
    end

    // Output words; the command word carries the transmit flag
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `RSAC_NWORDS; i++) begin
                outw[i] <= 16'h0000;
            end
        end else if (fire & pwrite & (s[5:4] == 2'h0)) begin
            // Software must write zero before each new command
            // and keep reserved setup bits zero
            outw[s[3:0]] <= pwdata[15:0];
        end
    end
endmodule
`default_nettype wire

// >>> hdl/rsac_device.sv
/*
 * Module end: command interpreter for the two-channel resolver interface.
 * Decodes setup words, leaves setup by save or discard, enters alignment
 * mode and builds the ten-word input block.
 * Assumes the host end and the resolver front end share this clock.
 */
// The implementer's own choices: the APB interface to the registers and the address map.
`include "rsac_params.svh"
`default_nettype none
module rsac_device (
    input wire logic clock,
    input wire logic rst_n,
    rsac_link_if.dev link,
    input wire logic [15:0] angle_ch1,
    input wire logic [15:0] angle_ch2,
    input wire logic [1:0] pos_ok,
    input wire logic [31:0] turns_pos,
    output logic [1:0] dir_ccw,
    output logic vernier,
    output logic [1:0] fault,
    output logic [1:0] mode_state,
    output logic nv_write
);
    // True when words lo..9 of the output block are zero
    function automatic logic rest_zero(input rsac_pkg::rsac_word_t w [10], input int lo);
        logic z;
        z = 1'b1;
        for (int i = 1; i < `RSAC_NWORDS; i++) begin
            if (i >= lo && w[i] != 16'h0000) begin
                z = 1'b0;
            end
        end
        return z;
    endfunction

    // Alignment position at fixed resolution, turned for count direction
    function automatic logic [15:0] align_pos(input logic [15:0] a, input logic ccw);
        logic [9:0] p;
        p = a[15:16-`RSAC_ALIGN_BITS];
        if (ccw) begin
            p = 10'h000 - p;
        end
        return {6'h00, p};
    endfunction

    rsac_pkg::rsac_word_t cmd;           // Command word
    logic xmit;                           // Transmit flag
    logic xmit_q;                         // Transmit flag one cycle ago
    logic take;                           // Command accepted this cycle
    rsac_pkg::rsac_mode_e mode;           // Current operating mode
    rsac_pkg::rsac_mode_e next_mode;      // Mode after this command
    rsac_pkg::rsac_cfg_e cfg_live;        // Saved configuration in force
    rsac_pkg::rsac_cfg_e cfg_pend;        // Configuration written in setup
    rsac_pkg::rsac_word_t sw_live [2];    // Saved setup words in force
    rsac_pkg::rsac_word_t sw_pend [2];    // Setup words written in setup
    logic initialized;                    // Valid saved setup exists
    logic aligned;                        // Align-transducer has succeeded
    logic ack;                            // Acknowledge flag
    logic [3:0] err;                      // Response error code
    logic ok;                             // Command recognised and legal
    logic fclr;                           // Host fault clear accepted
    logic [15:0] ms_word;                 // Module status word

    assign cmd = link.out_w[0];
    assign xmit = cmd[`RSAC_XMIT_BIT];
    assign take = xmit & ~xmit_q;         // Only a 0 to 1 edge counts
    assign fclr = take & (cmd == `RSAC_CMD_FAULT_CLR) & rest_zero(link.out_w, 1);

    // Edge detector on the transmit flag; link is on this clock already
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xmit_q <= 1'b0;
        end else begin
            xmit_q <= xmit;
        end
    end

    // Command decode: picks the next mode and whether the command is legal
    always_comb begin
        next_mode = mode;
        ok = 1'b0;
        unique case (cmd)
            `RSAC_CMD_SAVE_EXIT: begin
                ok = (mode != rsac_pkg::RSAC_MODE_MEAS) & rest_zero(link.out_w, 1);
                if (mode == rsac_pkg::RSAC_MODE_SETUP) begin
                    // Foreign dual pairs must be aligned next
                    next_mode = (cfg_pend == rsac_pkg::RSAC_CFG_FOREIGN) ?
                        rsac_pkg::RSAC_MODE_ALIGN : rsac_pkg::RSAC_MODE_MEAS;
                end else begin
                    next_mode = rsac_pkg::RSAC_MODE_MEAS;
                end
            end
            `RSAC_CMD_EXIT: begin
                ok = (mode != rsac_pkg::RSAC_MODE_MEAS) & rest_zero(link.out_w, 1);
                next_mode = rsac_pkg::RSAC_MODE_MEAS;
            end
            `RSAC_CMD_ALIGN_ENTER: begin
                // Password, zero tail and valid saved setup all needed
                ok = (link.out_w[1] == `RSAC_ALIGN_PASSWORD) & rest_zero(link.out_w, 2) & initialized;
                next_mode = rsac_pkg::RSAC_MODE_ALIGN;
            end
            `RSAC_CMD_ALIGN_XDCR: begin
                // Single resolvers or a faulted channel cannot be aligned
                ok = (mode == rsac_pkg::RSAC_MODE_ALIGN) & (cfg_live != rsac_pkg::RSAC_CFG_SINGLE) &
                     (fault == 2'h0) & rest_zero(link.out_w, 1);
            end
            `RSAC_CMD_SETUP_ENTER: begin
                ok = rest_zero(link.out_w, 1);
                next_mode = rsac_pkg::RSAC_MODE_SETUP;
            end
            `RSAC_CMD_FAULT_CLR: begin
                ok = rest_zero(link.out_w, 1);
            end
            `RSAC_CMD_PROG_CH1, `RSAC_CMD_PROG_CH2, `RSAC_CMD_PROG_BOTH,
            `RSAC_CMD_PROG_NATIVE, `RSAC_CMD_PROG_FOREIGN: begin
                ok = (mode == rsac_pkg::RSAC_MODE_SETUP);
            end
            default: begin
                ok = 1'b0; // Unknown word: error, mode unchanged
            end
        endcase
        if (!ok) begin
            next_mode = mode;
        end
    end

    // Mode register and alignment state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode <= rsac_pkg::RSAC_MODE_SETUP;
            aligned <= 1'b0;
        end else if (take & ok) begin
            mode <= next_mode;
            if (cmd == `RSAC_CMD_ALIGN_XDCR) begin
                aligned <= 1'b1;
            end else if (cmd == `RSAC_CMD_ALIGN_ENTER) begin
                aligned <= 1'b0;
            end
        end
    end

    // Acknowledge and error code; set on accepted edge, ack cleared on transmit low, error code held
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            err <= `RSAC_ERR_NONE;
        end else if (take) begin
            ack <= 1'b1;
            err <= ok ? `RSAC_ERR_NONE : `RSAC_ERR_CMD;
        end else if (!xmit) begin
            ack <= 1'b0;
        end
    end

    // Pending setup data: written in setup, dropped on discard
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_pend[0] <= `RSAC_SW_RESET;
            sw_pend[1] <= `RSAC_SW_RESET;
            cfg_pend <= rsac_pkg::RSAC_CFG_SINGLE;
        end else if (take & ok & (mode == rsac_pkg::RSAC_MODE_SETUP)) begin
            unique case (cmd)
                `RSAC_CMD_PROG_CH1: begin
                    sw_pend[0] <= link.out_w[1];
                    cfg_pend <= rsac_pkg::RSAC_CFG_SINGLE;
                end
                `RSAC_CMD_PROG_CH2: begin
                    sw_pend[1] <= link.out_w[5];
                    cfg_pend <= rsac_pkg::RSAC_CFG_SINGLE;
                end
                `RSAC_CMD_PROG_BOTH: begin
                    sw_pend[0] <= link.out_w[1];
                    sw_pend[1] <= link.out_w[5];
                    cfg_pend <= rsac_pkg::RSAC_CFG_SINGLE;
                end
                `RSAC_CMD_PROG_NATIVE, `RSAC_CMD_PROG_FOREIGN: begin
                    // One setup word governs both resolvers of a dual pair
                    sw_pend[0] <= link.out_w[1];
                    sw_pend[1] <= link.out_w[1];
                    cfg_pend <= (cmd == `RSAC_CMD_PROG_FOREIGN) ?
                        rsac_pkg::RSAC_CFG_FOREIGN : rsac_pkg::RSAC_CFG_NATIVE;
                end
                `RSAC_CMD_EXIT: begin
                    sw_pend <= sw_live;
                    cfg_pend <= cfg_live;
                end
                default: begin
                end
            endcase
        end
    end

    // Saved setup: only a save-and-exit copies pending into force
    // A reset empties it, standing in for loss of unsaved edits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_live[0] <= `RSAC_SW_RESET;
            sw_live[1] <= `RSAC_SW_RESET;
            cfg_live <= rsac_pkg::RSAC_CFG_SINGLE;
            initialized <= 1'b0;
            nv_write <= 1'b0;
        end else begin
            nv_write <= 1'b0;
            if (take & ok & (cmd == `RSAC_CMD_SAVE_EXIT) & (mode == rsac_pkg::RSAC_MODE_SETUP)) begin
                sw_live <= sw_pend;
                cfg_live <= cfg_pend;
                initialized <= 1'b1;
                nv_write <= 1'b1;
            end
        end
    end

    // Decoded controls from the saved setup words, and the mode copied to mode_state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dir_ccw <= 2'h0;
            vernier <= 1'b0;
            mode_state <= 2'h0;
        end else begin
            dir_ccw <= {sw_live[1][`RSAC_SW_DIR], sw_live[0][`RSAC_SW_DIR]};
            // Gearing only matters for a foreign dual pair
            vernier <= (cfg_live == rsac_pkg::RSAC_CFG_FOREIGN) & sw_live[0][`RSAC_SW_GEAR];
            mode_state <= mode;
        end
    end

    // Transducer fault flags, per channel; a new fault wins over a clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!pos_ok[c]) begin
                    fault[c] <= 1'b1;
                end else if (mode == rsac_pkg::RSAC_MODE_ALIGN) begin
                    fault[c] <= 1'b0;
                end else if (!sw_live[c][`RSAC_SW_LATCH]) begin
                    fault[c] <= 1'b0;
                end else if (fclr) begin
                    fault[c] <= 1'b0;
                end
            end
        end
    end

    assign ms_word = {ack, 1'b0, (mode == rsac_pkg::RSAC_MODE_ALIGN), initialized, 8'h00, err};

    // Input block, registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `RSAC_NWORDS; i++) begin
                link.in_w[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < `RSAC_NWORDS; i++) begin
                link.in_w[i] <= 16'h0000;
            end
            link.in_w[0] <= ms_word;
            link.in_w[1] <= {fault[0], aligned, 14'h0000};
            link.in_w[5] <= {fault[1], aligned, 14'h0000};
            if (mode == rsac_pkg::RSAC_MODE_ALIGN) begin
                if (aligned) begin
                    link.in_w[2] <= turns_pos[15:0];
                    link.in_w[3] <= turns_pos[31:16];
                end else begin
                    link.in_w[3] <= align_pos(angle_ch1, dir_ccw[0]);
                    link.in_w[7] <= align_pos(angle_ch2, dir_ccw[1]);
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/rsac_link_checker.sv
/*
 * Link checker: watches the command handshake and the input block.
 * Assumes the bench hands it the link words, clock and reset.
 */
`include "rsac_params.svh"
`default_nettype none
module rsac_link_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire rsac_pkg::rsac_word_t out_w [10],
    input wire rsac_pkg::rsac_word_t in_w [10]
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Short names for the handshake bits, the status bits and the error code
    wire logic tx = out_w[0][`RSAC_XMIT_BIT];
    wire logic ack = in_w[0][`RSAC_MS_ACK];
    wire logic aln = in_w[0][`RSAC_MS_ALIGN];
    wire logic ini = in_w[0][`RSAC_MS_INIT];
    wire logic [3:0] err = in_w[0][3:0];
    // A command is taken on the transmit rising edge only
    sequence take_s;
        $rose(tx);
    endsequence
    sequence enter_s;
        take_s ##0 (out_w[0] == `RSAC_CMD_ALIGN_ENTER);
    endsequence
    ack_answer_a: assert property (take_s |-> ##2 ack)
        else $error("ack missing after command");
    ack_cause_a: assert property ($rose(ack) |-> $past(tx, 2) && !$past(tx, 3))
        else $error("ack without transmit edge");
    ack_hold_a: assert property (ack && tx |=> ack)
        else $error("ack dropped while transmit high");
    ack_clear_a: assert property ($fell(tx) |-> ##2 !ack)
        else $error("ack not cleared");
    // A new error code only ever arrives together with a fresh acknowledge
    err_code_a: assert property (err inside {`RSAC_ERR_NONE, `RSAC_ERR_CMD}
        && (!$changed(err) || $rose(ack)))
        else $error("bad error code");
    // Alignment block layout; the range bound catches a wrong resolution
    align_zero_a: assert property (aln |-> in_w[4] == 0 && in_w[6] == 0 && in_w[8] == 0 && in_w[9] == 0)
        else $error("nonzero spare word in alignment");
    align_range_a: assert property (aln && !in_w[1][`RSAC_CS_ALIGNED]
        |-> in_w[2] == 0 && in_w[3][15:10] == 0 && in_w[7][15:10] == 0)
        else $error("alignment position out of range");
    align_enter_a: assert property (enter_s ##0 (out_w[1] == `RSAC_ALIGN_PASSWORD && ini)
        |-> ##2 ack && aln && err == `RSAC_ERR_NONE)
        else $error("alignment entry not accepted");
    align_init_a: assert property (enter_s ##0 !ini |-> ##2 err == `RSAC_ERR_CMD && !aln)
        else $error("alignment entered uninitialized");
    bad_pass_a: assert property (enter_s ##0 (out_w[1] != `RSAC_ALIGN_PASSWORD)
        |-> ##2 err == `RSAC_ERR_CMD && aln == $past(aln, 2))
        else $error("wrong password not refused");
    exit_mode_a: assert property (take_s ##0 (out_w[0] == `RSAC_CMD_EXIT && !aln) |-> ##2 ack && !aln)
        else $error("exit entered alignment");
endmodule
`default_nettype wire

// >>> verif/rsac_bench.sv
/*
 * Self-checking bench: both ends joined by the link, host driven over APB.
 * Assumes the include files and both design ends are compiled first.
 */
`include "rsac_params.svh"
`default_nettype none
module rsac_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] angle_ch1 = 16'h0000;
    logic [15:0] angle_ch2 = 16'h0000;
    logic [1:0] pos_ok = 2'b11;
    logic [31:0] turns_pos = 32'h0;
    logic [1:0] dir_ccw;
    logic vernier;
    logic [1:0] fault;
    logic [1:0] mode_state;
    logic nv_write;
    logic [31:0] rdata; // Last read data
    logic slverr; // Last error response
    logic [31:0] stat; // Status seen while ack was high
    rsac_pkg::rsac_word_t blk [10]; // Staged output block
    int err_count = 0;
    int comparisons = 0;
    int nv_count = 0;
    rsac_link_if link ();
    rsac_host i_rsac_host (.clock(clock), .rst_n(rst_n), .link(link), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rsac_device i_rsac_device (.clock(clock), .rst_n(rst_n), .link(link), .angle_ch1(angle_ch1),
        .angle_ch2(angle_ch2), .pos_ok(pos_ok), .turns_pos(turns_pos), .dir_ccw(dir_ccw),
        .vernier(vernier), .fault(fault), .mode_state(mode_state), .nv_write(nv_write));
    rsac_link_checker i_rsac_link_checker (.clock(clock), .rst_n(rst_n), .out_w(link.out_w), .in_w(link.in_w));
    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end
    // Counts commit pulses, so a doubled pulse shows too
    always @(posedge clock) begin
        if (nv_write === 1'b1) begin
            nv_count++;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; an idle cycle first keeps psel from being assigned twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Polls module status until ack reads the wanted level
    task automatic wait_ack(input logic want);
        int n;
        n = 0;
        do begin
            apb(1'b0, `RSAC_IN_BASE, 32'h0);
            n++;
        end while (rdata[15] !== want && n < 20);
        stat = rdata;
        chk(32'(rdata[15]), 32'(want));
    endtask
    // Words 1..9 first, command word last, then transmit low
    task automatic send(input rsac_pkg::rsac_word_t cmd);
        logic [31:0] s;
        for (int i = 9; i > 0; i--) begin
            apb(1'b1, `RSAC_OUT_BASE + 8'(4 * i), {16'h0, blk[i]});
        end
        apb(1'b1, `RSAC_OUT_BASE, {16'h0, cmd});
        wait_ack(1'b1);
        s = stat;
        apb(1'b1, `RSAC_OUT_BASE, 32'h0);
        wait_ack(1'b0);
        stat = s;
        for (int i = 0; i < 10; i++) begin
            blk[i] = 16'h0;
        end
    endtask
    // Faults on both channels, then recovery
    task automatic pulse_fault();
        pos_ok <= 2'b00;
        apb(1'b0, 8'h44, 32'h0);
        pos_ok <= 2'b11;
        apb(1'b0, 8'h44, 32'h0);
        apb(1'b0, 8'h44, 32'h0);
    endtask
    task automatic final_report();
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        for (int i = 0; i < 10; i++) begin
            blk[i] = 16'h0;
        end
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, `RSAC_IN_BASE, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        chk(32'(slverr), 32'h1);
        apb(1'b1, `RSAC_IN_BASE, 32'hFFFF);
        chk(32'(slverr), 32'h1);
        blk[1] = `RSAC_ALIGN_PASSWORD;
        send(`RSAC_CMD_ALIGN_ENTER);
        chk(stat, 32'h8001);
        blk[1] = 16'h0003;
        blk[2] = 16'h0400;
        blk[6] = 16'h0400;
        send(`RSAC_CMD_PROG_BOTH);
        chk(stat & 32'h800F, 32'h8000);
        chk(32'(dir_ccw), 32'h0);
        send(`RSAC_CMD_EXIT);
        chk(32'(mode_state), 32'(rsac_pkg::RSAC_MODE_MEAS));
        chk(32'(dir_ccw), 32'h0);
        send(`RSAC_CMD_SETUP_ENTER);
        // Gearing bit set here must be ignored for single resolvers
        blk[1] = 16'h0103;
        blk[2] = 16'h0400;
        blk[6] = 16'h0400;
        send(`RSAC_CMD_PROG_BOTH);
        send(`RSAC_CMD_SAVE_EXIT);
        chk(stat & 32'h800F, 32'h8000);
        chk(32'(nv_count), 32'h1);
        chk(32'(mode_state), 32'(rsac_pkg::RSAC_MODE_MEAS));
        chk(32'(dir_ccw), 32'h1);
        chk(32'(vernier), 32'h0);
        apb(1'b0, `RSAC_IN_BASE, 32'h0);
        chk(rdata & 32'h300F, 32'h1000);
        pulse_fault();
        chk(32'(fault), 32'h1);
        chk(32'(rdata[15]), 32'h1);
        send(`RSAC_CMD_FAULT_CLR);
        chk(32'(fault), 32'h0);
        blk[1] = 16'h1299;
        send(`RSAC_CMD_ALIGN_ENTER);
        chk(stat & 32'h200F, 32'h1);
        chk(32'(mode_state), 32'(rsac_pkg::RSAC_MODE_MEAS));
        // Unknown command word: acknowledged with command error
        send(16'hC000);
        chk(stat & 32'h800F, 32'h8001);
        chk(32'(mode_state), 32'(rsac_pkg::RSAC_MODE_MEAS));
        angle_ch1 <= 16'hABCD;
        angle_ch2 <= 16'h1234;
        blk[1] = `RSAC_ALIGN_PASSWORD;
        send(`RSAC_CMD_ALIGN_ENTER);
        chk(stat & 32'hB00F, 32'hB000);
        chk(32'(mode_state), 32'(rsac_pkg::RSAC_MODE_ALIGN));
        apb(1'b0, 8'h4C, 32'h0);
        chk(rdata, 32'h151);
        apb(1'b0, 8'h5C, 32'h0);
        chk(rdata, 32'h48);
        pulse_fault();
        chk(32'(fault), 32'h0);
        // Native dual pair: gearing bit ignored, save goes to measurement
        send(`RSAC_CMD_SETUP_ENTER);
        blk[1] = 16'h0100;
        send(`RSAC_CMD_PROG_NATIVE);
        send(`RSAC_CMD_SAVE_EXIT);
        chk(32'(mode_state), 32'(rsac_pkg::RSAC_MODE_MEAS));
        chk(32'(vernier), 32'h0);
        send(`RSAC_CMD_SETUP_ENTER);
        blk[1] = 16'h0100;
        blk[2] = 16'h0040;
        blk[3] = 16'h0040;
        blk[4] = 16'h0400;
        send(`RSAC_CMD_PROG_FOREIGN);
        send(`RSAC_CMD_SAVE_EXIT);
        chk(32'(mode_state), 32'(rsac_pkg::RSAC_MODE_ALIGN));
        chk(32'(vernier), 32'h1);
        turns_pos <= 32'h00B3A291;
        send(`RSAC_CMD_ALIGN_XDCR);
        apb(1'b0, 8'h48, 32'h0);
        chk(rdata, 32'hA291);
        apb(1'b0, 8'h4C, 32'h0);
        chk(rdata, 32'hB3);
        final_report();
    end
    // Cuts a hang well past the fewer than a thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
